// [fault_ctl_pkg.sv]
// constants for fault flag, interrupt and reset control
`default_nettype none

package fault_ctl_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int STEP_M_W = 4;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] OFF_DEVICE_LIVE      = 16'h000C;
  localparam logic [15:0] OFF_INPUT_LIVE       = 16'h000D;
  localparam logic [15:0] OFF_LOOP_LIVE        = 16'h000E;
  localparam logic [15:0] OFF_CALIB_LIVE       = 16'h000F;
  localparam logic [15:0] OFF_DEVICE_FLAGS     = 16'h0011;
  localparam logic [15:0] OFF_INPUT_FLAGS      = 16'h0012;
  localparam logic [15:0] OFF_LOOP_FLAGS       = 16'h0013;
  localparam logic [15:0] OFF_CALIB_FLAGS      = 16'h0014;
  localparam logic [15:0] OFF_DEVICE_MASKS     = 16'h0017;
  localparam logic [15:0] OFF_INPUT_MASKS      = 16'h0018;
  localparam logic [15:0] OFF_LOOP_MASKS       = 16'h0019;
  localparam logic [15:0] OFF_CALIB_MASKS      = 16'h001A;
  localparam logic [15:0] OFF_RESTART_STROBES  = 16'h001C;
  localparam logic [15:0] OFF_STEP_STROBES     = 16'h001D;
  localparam logic [15:0] OFF_POWER_CTL        = 16'h001E;
  localparam logic [15:0] OFF_BW_APPLY_A       = 16'h0414;
  localparam logic [15:0] OFF_BW_APPLY_B       = 16'h0514;

  // ------------------------------------------------------------
  // implemented bits of each register
  // ------------------------------------------------------------
  localparam logic [7:0] VALID_DEVICE = 8'h2F;
  localparam logic [7:0] VALID_INPUT  = 8'hFF;
  localparam logic [7:0] VALID_LOOP   = 8'h33;
  localparam logic [7:0] VALID_CALIB  = 8'h30;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_DEV_RESTART  = 0;
  localparam int BIT_LOOPA_RESTART = 1;
  localparam int BIT_LOOPB_RESTART = 2;
  localparam int BIT_STEP_UP      = 0;
  localparam int BIT_STEP_DOWN    = 1;
  localparam int BIT_POWER_DOWN   = 0;
  localparam int BIT_FULL_RESET   = 1;
  localparam int BIT_REALIGN      = 2;
  localparam int BIT_BW_APPLY     = 0;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_MASKS      = 8'h00;
  localparam logic       RST_POWER_DOWN = 1'b0;
  localparam logic       RST_PIN_IDLE   = 1'b1;

endpackage : fault_ctl_pkg

`default_nettype wire

// [pin_sync.sv]
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
  parameter logic RESET_VAL = 1'b1
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // pin and synchronised level
  input  wire logic pin_in,
  output var  logic pin_sync_out
);

  logic stage1_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1_reg   <= RESET_VAL;
      pin_sync_out <= RESET_VAL;
    end
    else
    begin
      stage1_reg   <= pin_in;
      pin_sync_out <= stage1_reg;
    end
  end

endmodule : pin_sync

`default_nettype wire

// [sticky_flag_bank.sv]
// one register of sticky fault flags with guarded clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_bank
#(
  parameter logic [7:0] VALID_MASK = 8'hFF
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // live conditions
  input  wire logic [7:0] live,
  // register write
  input  wire logic       wr_sel,
  input  wire logic [7:0] wr_data,
  // flags
  output var  logic [7:0] flags_reg
);
  import fault_ctl_pkg::*;

  logic [7:0] clear_bits;
  logic [7:0] flags_next;

  always_comb
  begin
    // a zero written clears only where the live condition is gone
    clear_bits = wr_sel ? (~wr_data & ~live) : 8'h00;
    // live set wins over any clear
    flags_next = ((flags_reg & ~clear_bits) | live) & VALID_MASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      flags_reg <= RST_FLAGS;
    else
      flags_reg <= flags_next;
  end

endmodule : sticky_flag_bank

`default_nettype wire

// [fault_flag_irq_and_reset_ctl.sv]
// fault flags, interrupt masking and reset strobes of the synthesizer
//
// What this block does
// - sticky signal-absent flags, bits 3:0, set by live input loss.
// - sticky out-of-range flags, bits 7:4, set by live frequency fault.
// - a sticky flag clears only by software writing zero to it.
// - clear is refused while the matching live status bit is one.
// - sticky unlock flag per loop in bits 1:0.
// - sticky holdover flag per loop in bits 5:4.
// - sticky calibration flag per loop in bits 5:4 of own register.
// - device mask bits 0,1,2,3,5 block device flags from interrupt.
// - input mask bits 3:0 and 7:4 block input flags.
// - loop mask bits 1:0 and 5:4 block unlock and holdover flags.
// - calibration mask bits 5:4 block calibration flags.
// - writing one to bit 0 restarts whole device without reload.
// - bits 1 and 2 restart loop A or loop B only.
// - whole restart also applies pending bandwidth and divider values.
// - loop restarts never apply pending bandwidth values.
// - rising written step-up bit steps loop A up if unmasked.
// - rising written step-down bit steps loop A down if unmasked.
// - power-down bit one enters low power; zero is normal.
// - registers stay fully usable while powered down.
// - writing one to bit 1 requests hard reset with reload.
// - writing realign bit resets dividers like the realign pin.
// - live input status shows loss 3:0 and out-of-range 7:4.
// - device sticky flags bits 0,1,2,3,5 latch device live status.
`timescale 1ns/1ps
`default_nettype none

module fault_flag_irq_and_reset_ctl
(
  // clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  // register access from the serial port
  input  wire logic                                reg_wr_en,
  input  wire logic                                reg_rd_en,
  input  wire logic [fault_ctl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [fault_ctl_pkg::DATA_W-1:0]    reg_wr_data,
  output var  logic [fault_ctl_pkg::DATA_W-1:0]    reg_rd_data,
  output var  logic                                reg_rd_valid,
  // live device conditions
  input  wire logic                                calibrating,
  input  wire logic                                ref_absent,
  input  wire logic                                ref_signal_lost,
  input  wire logic                                ref_error,
  input  wire logic                                bus_timeout,
  // live input and loop conditions
  input  wire logic [3:0]                          signal_absent,
  input  wire logic [3:0]                          freq_out_of_range,
  input  wire logic [1:0]                          loop_unlocked,
  input  wire logic [1:0]                          loop_holdover,
  input  wire logic [1:0]                          loop_calib_busy,
  input  wire logic [fault_ctl_pkg::STEP_M_W-1:0]  step_mask_bits,
  // pins
  input  wire logic                                divider_realign_pin_n,
  output var  logic                                interrupt_out_n,
  // control outputs
  output var  logic                                device_restart_pulse,
  output var  logic [1:0]                          loop_restart_pulse,
  output var  logic [1:0]                          bw_apply_pulse,
  output var  logic                                divider_update_pulse,
  output var  logic                                freq_step_up_pulse,
  output var  logic                                freq_step_down_pulse,
  output var  logic                                power_down_ctl,
  output var  logic                                full_reset_pulse,
  output var  logic                                divider_realign_out
);
  import fault_ctl_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0] device_live, input_live, loop_live, calib_live;
  logic [7:0] device_flags, input_flags, loop_flags, calib_flags;
  logic [7:0] device_mask_reg, input_mask_reg, loop_mask_reg;
  logic [7:0] calib_mask_reg;
  logic [1:0] step_last_reg;
  logic       realign_sync, wr_restart, wr_step, wr_power;
  logic       step_enabled, irq_pending;

  // ------------------------------------------------------------
  // live status mapping
  // ------------------------------------------------------------
  always_comb
  begin
    device_live = {2'b00, bus_timeout, 1'b0, ref_error, ref_signal_lost,
                   ref_absent, calibrating} & VALID_DEVICE;
    input_live  = {freq_out_of_range, signal_absent};
    loop_live   = {2'b00, loop_holdover, 2'b00, loop_unlocked};
    calib_live  = {2'b00, loop_calib_busy, 4'h0};
  end

  // ------------------------------------------------------------
  // sticky flag registers
  // ------------------------------------------------------------
  sticky_flag_bank #(.VALID_MASK(VALID_DEVICE)) u_device_flags
  (
    .core_clk (core_clk), .rst_n (rst_n), .wr_data (reg_wr_data),
    .wr_sel   (reg_wr_en && hit(reg_addr, OFF_DEVICE_FLAGS)),
    .live     (device_live), .flags_reg (device_flags)
  );

  sticky_flag_bank #(.VALID_MASK(VALID_INPUT)) u_input_flags
  (
    .core_clk (core_clk), .rst_n (rst_n), .wr_data (reg_wr_data),
    .wr_sel   (reg_wr_en && hit(reg_addr, OFF_INPUT_FLAGS)),
    .live     (input_live), .flags_reg (input_flags)
  );

  sticky_flag_bank #(.VALID_MASK(VALID_LOOP)) u_loop_flags
  (
    .core_clk (core_clk), .rst_n (rst_n), .wr_data (reg_wr_data),
    .wr_sel   (reg_wr_en && hit(reg_addr, OFF_LOOP_FLAGS)),
    .live     (loop_live), .flags_reg (loop_flags)
  );

  sticky_flag_bank #(.VALID_MASK(VALID_CALIB)) u_calib_flags
  (
    .core_clk (core_clk), .rst_n (rst_n), .wr_data (reg_wr_data),
    .wr_sel   (reg_wr_en && hit(reg_addr, OFF_CALIB_FLAGS)),
    .live     (calib_live), .flags_reg (calib_flags)
  );

  // ------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      device_mask_reg <= RST_MASKS;
      input_mask_reg  <= RST_MASKS;
      loop_mask_reg   <= RST_MASKS;
      calib_mask_reg  <= RST_MASKS;
    end
    else if (reg_wr_en)
    begin
      if (hit(reg_addr, OFF_DEVICE_MASKS))
        device_mask_reg <= reg_wr_data & VALID_DEVICE;
      if (hit(reg_addr, OFF_INPUT_MASKS))
        input_mask_reg <= reg_wr_data & VALID_INPUT;
      if (hit(reg_addr, OFF_LOOP_MASKS))
        loop_mask_reg <= reg_wr_data & VALID_LOOP;
      if (hit(reg_addr, OFF_CALIB_MASKS))
        calib_mask_reg <= reg_wr_data & VALID_CALIB;
    end
  end

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  always_comb
  begin
    irq_pending = (|(device_flags & ~device_mask_reg))
               || (|(input_flags & ~input_mask_reg))
               || (|(loop_flags & ~loop_mask_reg))
               || (|(calib_flags & ~calib_mask_reg));
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      interrupt_out_n <= 1'b1;
    else
      interrupt_out_n <= !irq_pending;
  end

  // ------------------------------------------------------------
  // restart and bandwidth strobes
  // ------------------------------------------------------------
  always_comb
  begin
    wr_restart   = reg_wr_en && hit(reg_addr, OFF_RESTART_STROBES);
    wr_step      = reg_wr_en && hit(reg_addr, OFF_STEP_STROBES);
    wr_power     = reg_wr_en && hit(reg_addr, OFF_POWER_CTL);
    step_enabled = (step_mask_bits == '0);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      device_restart_pulse <= 1'b0;
      loop_restart_pulse   <= 2'b00;
      bw_apply_pulse       <= 2'b00;
      divider_update_pulse <= 1'b0;
    end
    else
    begin
      device_restart_pulse <= wr_restart && reg_wr_data[BIT_DEV_RESTART];
      loop_restart_pulse   <= wr_restart ?
        {reg_wr_data[BIT_LOOPB_RESTART], reg_wr_data[BIT_LOOPA_RESTART]}
        : 2'b00;
      // loop restarts do not feed the bandwidth apply path
      bw_apply_pulse[0] <= (wr_restart && reg_wr_data[BIT_DEV_RESTART])
        || (reg_wr_en && hit(reg_addr, OFF_BW_APPLY_A)
            && reg_wr_data[BIT_BW_APPLY]);
      bw_apply_pulse[1] <= (wr_restart && reg_wr_data[BIT_DEV_RESTART])
        || (reg_wr_en && hit(reg_addr, OFF_BW_APPLY_B)
            && reg_wr_data[BIT_BW_APPLY]);
      divider_update_pulse <= wr_restart && reg_wr_data[BIT_DEV_RESTART];
    end
  end

  // ------------------------------------------------------------
  // frequency steps
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      step_last_reg        <= 2'b00;
      freq_step_up_pulse   <= 1'b0;
      freq_step_down_pulse <= 1'b0;
    end
    else
    begin
      if (wr_step)
        step_last_reg <= {reg_wr_data[BIT_STEP_DOWN], reg_wr_data[BIT_STEP_UP]};
      freq_step_up_pulse <= wr_step && step_enabled
        && reg_wr_data[BIT_STEP_UP] && !step_last_reg[0];
      freq_step_down_pulse <= wr_step && step_enabled
        && reg_wr_data[BIT_STEP_DOWN] && !step_last_reg[1];
    end
  end

  // ------------------------------------------------------------
  // power down, hard reset, realign
  // ------------------------------------------------------------
  pin_sync #(.RESET_VAL(RST_PIN_IDLE)) u_realign_sync
  (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .pin_in       (divider_realign_pin_n),
    .pin_sync_out (realign_sync)
  );

  // register file runs regardless of power-down
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      power_down_ctl      <= RST_POWER_DOWN;
      full_reset_pulse    <= 1'b0;
      divider_realign_out <= 1'b0;
    end
    else
    begin
      if (wr_power)
        power_down_ctl <= reg_wr_data[BIT_POWER_DOWN];
      full_reset_pulse <= wr_power && reg_wr_data[BIT_FULL_RESET];
      divider_realign_out <= (wr_power && reg_wr_data[BIT_REALIGN])
        || !realign_sync;
    end
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
      begin
        case (reg_addr)
          OFF_DEVICE_LIVE:  reg_rd_data <= device_live;
          OFF_INPUT_LIVE:   reg_rd_data <= input_live;
          OFF_LOOP_LIVE:    reg_rd_data <= loop_live;
          OFF_CALIB_LIVE:   reg_rd_data <= calib_live;
          OFF_DEVICE_FLAGS: reg_rd_data <= device_flags;
          OFF_INPUT_FLAGS:  reg_rd_data <= input_flags;
          OFF_LOOP_FLAGS:   reg_rd_data <= loop_flags;
          OFF_CALIB_FLAGS:  reg_rd_data <= calib_flags;
          OFF_DEVICE_MASKS: reg_rd_data <= device_mask_reg;
          OFF_INPUT_MASKS:  reg_rd_data <= input_mask_reg;
          OFF_LOOP_MASKS:   reg_rd_data <= loop_mask_reg;
          OFF_CALIB_MASKS:  reg_rd_data <= calib_mask_reg;
          OFF_POWER_CTL:    reg_rd_data <= {7'h00, power_down_ctl};
          default:          reg_rd_data <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_loss_flag_set: assert property (
    (signal_absent != 4'h0) |=>
      ((input_flags[3:0] & $past(signal_absent)) == $past(signal_absent)))
    else $error("signal absent flag not set");
  a_range_flag_set: assert property (
    (freq_out_of_range != 4'h0) |=>
      ((input_flags[7:4] & $past(freq_out_of_range))
        == $past(freq_out_of_range)))
    else $error("out of range flag not set");
  a_flag_clear_write: assert property (
    ((($past(input_flags) & ~input_flags) != 8'h00) |->
      $past(reg_wr_en && hit(reg_addr, OFF_INPUT_FLAGS))))
    else $error("input flag fell without write");
  a_clear_live_guard: assert property (
    (($past(loop_flags) & ~loop_flags & $past(loop_live)) == 8'h00))
    else $error("loop flag cleared while live");
  a_loop_flags_set: assert property (
    (loop_unlocked != 2'b00 || loop_holdover != 2'b00) |=>
      ((loop_flags & $past(loop_live)) == $past(loop_live)))
    else $error("loop flag not set");
  a_calib_flag_set: assert property (
    (loop_calib_busy != 2'b00) ##1 1'b1 |->
      ((calib_flags[5:4] & $past(loop_calib_busy)) == $past(loop_calib_busy)))
    else $error("calibration flag not set");
  a_irq_follows: assert property (
    irq_pending |=> !interrupt_out_n)
    else $error("interrupt not asserted");
  a_irq_release: assert property (
    (!irq_pending)[*2] |-> interrupt_out_n)
    else $error("interrupt held with nothing pending");
  a_restart_pulse: assert property (
    (wr_restart && reg_wr_data[BIT_DEV_RESTART]) |=>
      device_restart_pulse ##1 !device_restart_pulse || $past(wr_restart, 1))
    else $error("device restart not one pulse");
  a_restart_applies: assert property (
    device_restart_pulse |-> (bw_apply_pulse == 2'b11) && divider_update_pulse)
    else $error("restart did not apply pending values");
  a_loop_no_bw: assert property (
    (loop_restart_pulse != 2'b00 && !device_restart_pulse) |->
      (bw_apply_pulse == 2'b00) || $past(reg_wr_en && reg_addr[10]))
    else $error("loop restart applied bandwidth");
  a_step_cause: assert property (
    freq_step_up_pulse |-> $past(wr_step && reg_wr_data[BIT_STEP_UP]
      && !step_last_reg[0] && step_enabled))
    else $error("step up without rising write");
  a_power_follow: assert property (
    wr_power |=> (power_down_ctl == $past(reg_wr_data[BIT_POWER_DOWN])))
    else $error("power down bit not stored");
  a_realign_pin: assert property (
    !realign_sync |=> divider_realign_out)
    else $error("realign pin not honoured");

  c_flag_cleared: cover property ($fell(input_flags[0]));
  c_irq_raised: cover property ($fell(interrupt_out_n));
  c_step_up: cover property (freq_step_up_pulse);
  c_device_restart: cover property (device_restart_pulse);

endmodule : fault_flag_irq_and_reset_ctl

`default_nettype wire

// [host_model.sv]
// host model driving the register port of the fault controller
`timescale 1ns/1ps
`default_nettype none

module host_model
(
  // clock
  input  wire logic        core_clk,
  // register port
  output var  logic        reg_wr_en,
  output var  logic        reg_rd_en,
  output var  logic [15:0] reg_addr,
  output var  logic [7:0]  reg_wr_data,
  input  wire logic [7:0]  reg_rd_data,
  input  wire logic        reg_rd_valid
);
  initial
  begin
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_addr    = 16'h5A5A;
    reg_wr_data = 8'hA5;
  end

  // one write; idle lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    @(posedge core_clk) #1;
    {reg_wr_en, reg_addr, reg_wr_data} = {1'b0, ~a, ~d};
  endtask : wr

  // one read; returns valid and data of the answer cycle
  task automatic rd(input logic [15:0] a, output logic [8:0] r);
    @(posedge core_clk) #1;
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(posedge core_clk) #1;
    {reg_rd_en, reg_addr} = {1'b0, ~a};
    r = {reg_rd_valid, reg_rd_data};
  endtask : rd

  // clear sticky flags by writing zero
  task automatic clr(input logic [15:0] a);
    wr(a, 8'h00);
  endtask : clr
endmodule : host_model

`default_nettype wire

// [fault_flag_irq_and_reset_ctl_tb.sv]
// self-checking bench of the fault controller
`timescale 1ns/1ps
`default_nettype none

module fault_flag_irq_and_reset_ctl_tb;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        reg_wr_en, reg_rd_en, reg_rd_valid, interrupt_out_n;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wr_data, reg_rd_data;
  logic        calibrating, ref_absent, ref_signal_lost, ref_error;
  logic        bus_timeout, divider_realign_pin_n, device_restart_pulse;
  logic        divider_update_pulse, freq_step_up_pulse, full_reset_pulse;
  logic        freq_step_down_pulse, power_down_ctl, divider_realign_out;
  logic [3:0]  signal_absent, freq_out_of_range, step_mask_bits;
  logic [1:0]  loop_unlocked, loop_holdover, loop_calib_busy;
  logic [1:0]  loop_restart_pulse, bw_apply_pulse;
  logic [18:0] lv;
  logic [9:0]  pul;
  int          errors   = 0;
  int          n_checks = 0;

  always #2.5 core_clk = ~core_clk;
  assign {calibrating, ref_absent, ref_signal_lost, ref_error, bus_timeout,
          signal_absent, freq_out_of_range, loop_unlocked, loop_holdover,
          loop_calib_busy} = lv;
  assign pul = {loop_restart_pulse, divider_realign_out, full_reset_pulse,
                freq_step_down_pulse, freq_step_up_pulse,
                divider_update_pulse, bw_apply_pulse, device_restart_pulse};

  fault_flag_irq_and_reset_ctl fault_flag_irq_and_reset_ctl_i
  (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .calibrating(calibrating), .ref_absent(ref_absent),
    .ref_signal_lost(ref_signal_lost), .ref_error(ref_error),
    .bus_timeout(bus_timeout), .signal_absent(signal_absent),
    .freq_out_of_range(freq_out_of_range), .loop_unlocked(loop_unlocked),
    .loop_holdover(loop_holdover), .loop_calib_busy(loop_calib_busy),
    .step_mask_bits(step_mask_bits),
    .divider_realign_pin_n(divider_realign_pin_n),
    .interrupt_out_n(interrupt_out_n),
    .device_restart_pulse(device_restart_pulse),
    .loop_restart_pulse(loop_restart_pulse), .bw_apply_pulse(bw_apply_pulse),
    .divider_update_pulse(divider_update_pulse),
    .freq_step_up_pulse(freq_step_up_pulse),
    .freq_step_down_pulse(freq_step_down_pulse),
    .power_down_ctl(power_down_ctl), .full_reset_pulse(full_reset_pulse),
    .divider_realign_out(divider_realign_out)
  );

  host_model host_model_i
  (
    .core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic live(input logic [18:0] v);
    @(posedge core_clk) #1;
    lv = v;
  endtask : live

  task automatic irq(input logic e);
    chk({9'h000, interrupt_out_n}, {9'h000, e});
  endtask : irq

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [8:0] r;
    host_model_i.rd(a, r);
    chk({1'b0, r}, {2'b01, e});
  endtask : rdc

  task automatic wrp(input logic [15:0] a, input logic [7:0] d,
                     input logic [9:0] e);
    host_model_i.wr(a, d);
    chk(pul, e);
    cyc(1);
    chk(pul, 10'h000);
  endtask : wrp

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] offs [12] = '{16'h0011, 16'h0012, 16'h0013, 16'h0014,
      16'h0017, 16'h0018, 16'h0019, 16'h001A, 16'h001C, 16'h001D,
      16'h001E, 16'h0050};
    irq(1'b1);
    foreach (offs[i]) rdc(offs[i], 8'h00);
  endtask : t_reset

  task automatic t_input();
    live({5'h00, 4'h5, 4'hA, 6'h00});
    live({5'h00, 4'h1, 4'h8, 6'h00});
    cyc(1);
    irq(1'b0);
    rdc(16'h000D, 8'h81);
    rdc(16'h0012, 8'hA5);
    host_model_i.clr(16'h0012);
    rdc(16'h0012, 8'h81);
    live(19'h00000);
    host_model_i.wr(16'h0012, 8'hA1);
    rdc(16'h0012, 8'h81);
    host_model_i.clr(16'h0012);
    rdc(16'h0012, 8'h00);
    irq(1'b1);
  endtask : t_input

  task automatic t_mask();
    logic [15:0] offs [4] = '{16'h0017, 16'h0018, 16'h0019, 16'h001A};
    logic [7:0]  vals [4] = '{8'h2F, 8'hFF, 8'h33, 8'h30};
    live({5'h1F, 4'hF, 4'hF, 2'b10, 2'b01, 2'b11});
    live(19'h00000);
    rdc(16'h0011, 8'h2F);
    rdc(16'h0013, 8'h12);
    rdc(16'h0014, 8'h30);
    foreach (offs[i]) host_model_i.wr(offs[i], 8'hFF);
    cyc(1);
    irq(1'b1);
    foreach (offs[i])
    begin
      rdc(offs[i], vals[i]);
      host_model_i.wr(offs[i], 8'h00);
      cyc(1);
      irq(1'b0);
      host_model_i.wr(offs[i], 8'hFF);
      cyc(1);
      irq(1'b1);
    end
  endtask : t_mask

  task automatic t_strobe();
    wrp(16'h001C, 8'h01, 10'h00F);
    wrp(16'h001C, 8'h02, 10'h100);
    wrp(16'h001C, 8'h04, 10'h200);
    wrp(16'h001C, 8'h00, 10'h000);
    wrp(16'h0414, 8'h01, 10'h002);
    wrp(16'h0514, 8'h01, 10'h004);
    wrp(16'h001D, 8'h01, 10'h010);
    wrp(16'h001D, 8'h01, 10'h000);
    wrp(16'h001D, 8'h02, 10'h020);
    wrp(16'h001D, 8'h00, 10'h000);
    step_mask_bits = 4'h8;
    wrp(16'h001D, 8'h03, 10'h000);
    step_mask_bits = 4'h0;
  endtask : t_strobe

  task automatic t_power();
    wrp(16'h001E, 8'h01, 10'h000);
    chk({9'h000, power_down_ctl}, 10'h001);
    host_model_i.wr(16'h0018, 8'h5A);
    rdc(16'h0018, 8'h5A);
    rdc(16'h001E, 8'h01);
    wrp(16'h001E, 8'h02, 10'h040);
    chk({9'h000, power_down_ctl}, 10'h000);
    wrp(16'h001E, 8'h04, 10'h080);
    divider_realign_pin_n = 1'b0;
    cyc(2);
    chk(pul, 10'h000);
    cyc(1);
    chk(pul, 10'h080);
    divider_realign_pin_n = 1'b1;
    cyc(4);
  endtask : t_power

  initial
  begin
    lv = 19'h00000;
    step_mask_bits = 4'h0;
    divider_realign_pin_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_input();
    t_mask();
    t_strobe();
    t_power();
    finish_test();
  end

  initial
  begin
    #20000;
    errors++;
    finish_test();
  end
endmodule : fault_flag_irq_and_reset_ctl_tb

`default_nettype wire
